// *** design/sps_spi_seq.v ***
// SPI host port sequencer: frame shifter, command decode, port status
`timescale 1ns/1ns
`default_nettype none
`include "sps_map.vh"
module sps_spi_seq (
  input  wire        clk,               // System clock, 25 MHz
  input  wire        nrst,              // Async reset, active low
  input  wire        host_protocol_pin, // High selects SPI host port
  input  wire        spi_sck,           // SPI clock from host
  input  wire        spi_ss_n,          // Frame select, active low
  input  wire        spi_mosi,          // Serial data in
  output reg         spi_miso,          // Serial data out
  output reg         spi_miso_oe,       // Drive enable for miso
  output reg         loc_rd,            // Local register read, pulse
  output reg         loc_wr,            // Local register write, pulse
  output reg  [7:0]  loc_addr,          // Local register offset
  output reg  [7:0]  loc_wdata,         // Local write data
  input  wire [7:0]  loc_rdata,         // Local read data, strobe cycle
  output reg  [3:0]  ds_req,            // Per-port transfer start, pulse
  output reg         ds_rnw,            // Transfer is a read
  output reg         ds_dev,            // Device select in port
  output reg  [7:0]  ds_addr,           // Downstream register offset
  output reg  [7:0]  ds_wdata,          // Downstream write data
  input  wire [3:0]  ds_done,           // Per-port completion, pulse
  input  wire [31:0] ds_rdata,          // Per-port read data, 8 each
  input  wire [3:0]  ds_nack,           // Per-port nack with done
  output reg  [3:0]  port_busy          // Per-port busy status
);

  // ==========================================================
  // Pin synchronisers
  wire sck_f;
  wire ss_n_f;
  wire mosi_f;
  wire proto_f;

  sps_sync #(.RST(1'b0)) u_sck (
    .clk  (clk),
    .nrst (nrst),
    .din  (spi_sck),
    .dout (sck_f)
  );

  sps_sync #(.RST(1'b1)) u_ss (
    .clk  (clk),
    .nrst (nrst),
    .din  (spi_ss_n),
    .dout (ss_n_f)
  );

  sps_sync #(.RST(1'b0)) u_mosi (
    .clk  (clk),
    .nrst (nrst),
    .din  (spi_mosi),
    .dout (mosi_f)
  );

  sps_sync #(.RST(1'b0)) u_proto (
    .clk  (clk),
    .nrst (nrst),
    .din  (host_protocol_pin),
    .dout (proto_f)
  );

  // ==========================================================
  // Edge detection on filtered levels
  reg sck_d_q;
  reg ss_d_q;

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sck_d_q <= 1'b0;
      ss_d_q  <= 1'b1;
    end else begin
      sck_d_q <= sck_f;
      ss_d_q  <= ss_n_f;
    end
  end

  wire spi_en   = (proto_f == `SPS_PROTO_SPI);
  wire sck_rise = sck_f & ~sck_d_q;
  wire ss_fall  = ~ss_n_f & ss_d_q;
  wire ss_rise  = ss_n_f & ~ss_d_q;

  // ==========================================================
  // Per-port trackers
  wire [3:0]  trk_busy;
  wire [31:0] trk_data;
  wire [3:0]  trk_nack;

  genvar gi;
  generate
    for (gi = 0; gi < `SPS_NPORTS; gi = gi + 1) begin : g_trk
      sps_port_trk u_trk (
        .clk       (clk),
        .nrst      (nrst),
        .start     (ds_req[gi]),
        .rd        (ds_rnw),
        .done      (ds_done[gi]),
        .rdata     (ds_rdata[gi*8 +: 8]),
        .nack      (ds_nack[gi]),
        .busy      (trk_busy[gi]),
        .data      (trk_data[gi*8 +: 8]),
        .nack_seen (trk_nack[gi])
      );
    end
  endgenerate

  // ==========================================================
  // Shift state and pending result
  reg [`SPS_FRAME_W-1:0] rx_q;
  reg [`SPS_FRAME_W-1:0] tx_q;
  reg [`SPS_CNT_W-1:0]   cnt_q;
  reg [`SPS_FRAME_W-1:0] resp_q;
  reg                    resp_ds_q;
  reg [1:0]              resp_port_q;
  reg                    lcap_q;

  // Decode of the frame held in the shift register
  wire        cmd_rd   = rx_q[`SPS_RW_BIT];
  wire [11:0] cmd_addr = rx_q[`SPS_ADDR_HI:`SPS_ADDR_LO];
  wire [1:0]  cmd_port = rx_q[`SPS_PORT_HI:`SPS_PORT_LO];
  wire        cmd_ds   = ~rx_q[`SPS_DS_BIT];
  wire        cmd_loc  = (rx_q[`SPS_PAGE_HI:`SPS_PAGE_LO] == `SPS_LOCAL_PAGE);
  wire        cmd_bad  = (cmd_addr == `SPS_BAD_ADDR);
  wire        cmd_full = (cnt_q == `SPS_CNT_FULL);
  wire        exec     = ss_rise & spi_en & cmd_full;
  wire [12:0] cmd_head = rx_q[`SPS_RW_BIT:`SPS_ADDR_LO];

  // Downstream result view, resolved when the result frame starts
  wire [7:0]  rp_data = trk_data[{resp_port_q, 3'b000} +: 8];
  reg  [15:0] ds_word;
  reg  [`SPS_FRAME_W-1:0] tx_load;

  always @* begin
    ds_word = `SPS_ZERO_WORD;
    if (trk_busy[resp_port_q]) begin
      ds_word = `SPS_BUSY_WORD;
    end else begin
      ds_word[`SPS_NACK_BIT] = trk_nack[resp_port_q];
      ds_word[7:0]           = rp_data;
    end
    if (resp_ds_q) begin
      tx_load = {resp_q[`SPS_RW_BIT:`SPS_ADDR_LO], ds_word};
    end else begin
      tx_load = resp_q;
    end
  end

  // ==========================================================
  // Serial shifter: previous result out while new frame comes in
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rx_q        <= {`SPS_FRAME_W{1'b0}};
      tx_q        <= {`SPS_FRAME_W{1'b0}};
      cnt_q       <= {`SPS_CNT_W{1'b0}};
      spi_miso    <= 1'b0;
      spi_miso_oe <= 1'b0;
    end else begin
      spi_miso_oe <= spi_en & ~ss_n_f;
      if (ss_fall) begin
        tx_q     <= tx_load;
        spi_miso <= tx_load[`SPS_RW_BIT];
        cnt_q    <= {`SPS_CNT_W{1'b0}};
      end else if (sck_rise && !ss_n_f) begin
        rx_q     <= {rx_q[`SPS_FRAME_W-2:0], mosi_f};
        tx_q     <= {tx_q[`SPS_FRAME_W-2:0], 1'b0};
        spi_miso <= tx_q[`SPS_FRAME_W-2];
        if (cnt_q != `SPS_CNT_MAX) begin
          cnt_q <= cnt_q + 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // Command execution on select release
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      resp_q      <= {`SPS_FRAME_W{1'b0}};
      resp_ds_q   <= 1'b0;
      resp_port_q <= 2'b00;
      lcap_q      <= 1'b0;
      loc_rd      <= 1'b0;
      loc_wr      <= 1'b0;
      loc_addr    <= 8'h00;
      loc_wdata   <= 8'h00;
      ds_req      <= 4'h0;
      ds_rnw      <= 1'b0;
      ds_dev      <= 1'b0;
      ds_addr     <= 8'h00;
      ds_wdata    <= 8'h00;
      port_busy   <= 4'h0;
    end else begin
      loc_rd    <= 1'b0;
      loc_wr    <= 1'b0;
      ds_req    <= 4'h0;
      lcap_q    <= 1'b0;
      port_busy <= trk_busy;
      // Local read data is taken in the strobe cycle, at its closing edge
      if (lcap_q) begin
        resp_q[7:0] <= loc_rdata;
      end
      if (exec) begin
        resp_q    <= rx_q;
        resp_ds_q <= 1'b0;
        if (cmd_bad) begin
          resp_q <= rx_q;
        end else if (cmd_ds) begin
          resp_port_q <= cmd_port;
          if (trk_busy[cmd_port]) begin
            resp_q <= {cmd_head, `SPS_REJ_WORD};
          end else begin
            ds_req[cmd_port] <= 1'b1;
            ds_rnw           <= cmd_rd;
            ds_dev           <= rx_q[`SPS_DEV_BIT];
            ds_addr          <= rx_q[`SPS_REG_HI:`SPS_REG_LO];
            ds_wdata         <= rx_q[7:0];
            resp_ds_q        <= cmd_rd;
            resp_q           <= {cmd_head, `SPS_ZERO_WORD | {8'h00, rx_q[7:0]}};
          end
        end else if (cmd_loc) begin
          loc_addr  <= rx_q[`SPS_REG_HI:`SPS_REG_LO];
          loc_wdata <= rx_q[7:0];
          if (cmd_rd) begin
            loc_rd <= 1'b1;
            lcap_q <= 1'b1;
            resp_q <= {cmd_head, `SPS_ZERO_WORD};
          end else begin
            loc_wr <= 1'b1;
          end
        end
      end
    end
  end

endmodule
`default_nettype wire

// *** shared/sps_map.vh ***
// Constants for the SPI host port sequencer
`ifndef SPS_MAP_VH
`define SPS_MAP_VH

// ==========================================================
// Frame layout
`define SPS_FRAME_W     29
`define SPS_CNT_W       5
`define SPS_CNT_FULL    5'h1D
`define SPS_CNT_MAX     5'h1F
`define SPS_RW_BIT      28
`define SPS_ADDR_HI     27
`define SPS_ADDR_LO     16
`define SPS_DS_BIT      27
`define SPS_PORT_HI     26
`define SPS_PORT_LO     25
`define SPS_DEV_BIT     24
`define SPS_REG_HI      23
`define SPS_REG_LO      16
`define SPS_PAGE_HI     27
`define SPS_PAGE_LO     24
`define SPS_BUSY_BIT    15
`define SPS_NACK_BIT    13
`define SPS_REJ_BIT     12

// ==========================================================
// Codes and words
`define SPS_LOCAL_PAGE  4'h8
`define SPS_BAD_ADDR    12'hFFF
`define SPS_ZERO_WORD   16'h0000
`define SPS_BUSY_WORD   16'h8000
`define SPS_REJ_WORD    16'h1000
`define SPS_NPORTS      4
`define SPS_PROTO_SPI   1'b1

// ==========================================================
// Timing
`define SPS_CLK_NS      40
`define SPS_LOC_GAP_NS  1000
`define SPS_LOC_GAP_CYC ((`SPS_LOC_GAP_NS + `SPS_CLK_NS - 1) / `SPS_CLK_NS)

`endif

// *** design/sps_sync.v ***
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ns
`default_nettype none
module sps_sync #(
  parameter RST = 1'b0                  // Level held during reset
) (
  input  wire clk,                      // System clock
  input  wire nrst,                     // Async reset, active low
  input  wire din,                      // Asynchronous input
  output reg  dout                      // Filtered level
);

  reg s1_q;
  reg s2_q;
  reg s3_q;

  // ==========================================================
  // Sync chain; level moves once stages two and three agree
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s1_q <= RST;
      s2_q <= RST;
      s3_q <= RST;
      dout <= RST;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        dout <= s3_q;
      end
    end
  end

endmodule
`default_nettype wire

// *** design/sps_port_trk.v ***
// Per-port downstream transfer tracker
`timescale 1ns/1ns
`default_nettype none
module sps_port_trk (
  input  wire       clk,                // System clock
  input  wire       nrst,               // Async reset, active low
  input  wire       start,              // Transfer issued, pulse
  input  wire       rd,                 // Issued transfer is a read
  input  wire       done,               // Downstream finished, pulse
  input  wire [7:0] rdata,              // Downstream read data
  input  wire       nack,               // Downstream saw a nack
  output reg        busy,               // Master still working
  output reg  [7:0] data,               // Last read result
  output reg        nack_seen           // Last transfer nacked
);

  reg rd_q;

  // ==========================================================
  // Busy from issue to completion; start wins over done
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      busy      <= 1'b0;
      rd_q      <= 1'b0;
      data      <= 8'h00;
      nack_seen <= 1'b0;
    end else begin
      if (start) begin
        busy <= 1'b1;
        rd_q <= rd;
      end else if (done) begin
        busy <= 1'b0;
      end
      if (done && !start) begin
        nack_seen <= nack;
        if (rd_q) begin
          data <= rdata;
        end
      end
    end
  end

endmodule
`default_nettype wire

// *** verification/sps_host.sv ***
// Host SPI controller model, mode 0, 29-bit frames
`timescale 1ns/1ns
`default_nettype none
module sps_host (
  input  wire logic clk,  // System clock
  input  wire logic miso, // Data from device
  output var  logic ss_n, // Frame select
  output var  logic sck,  // Link clock, still between frames
  output var  logic mosi  // Data to device
);
  initial begin
    ss_n = 1'b1;
    sck = 1'b0;
    mosi = 1'b0;
  end
  // One whole frame, MSB first, then the deselect gap
  task automatic xfer(input logic [28:0] tx, input int gap, output logic [28:0] rx);
    @(negedge clk) ss_n = 1'b0;
    repeat (8) @(negedge clk);
    for (int b = 28; b >= 0; b--) begin
      mosi = tx[b];
      repeat (4) @(negedge clk);
      sck = 1'b1;
      rx[b] = miso;
      repeat (4) @(negedge clk);
      sck = 1'b0;
    end
    repeat (4) @(negedge clk);
    ss_n = 1'b1;
    mosi = ~mosi; // Released line shows no stale bit
    repeat (gap) @(negedge clk);
  endtask
endmodule
`default_nettype wire

// *** verification/sps_spi_seq_assertions.sv ***
// Port checker for the SPI host port sequencer
`timescale 1ns/1ns
`default_nettype none
module sps_chk (
  input wire logic       clk,               // System clock
  input wire logic       nrst,              // Async reset, active low
  input wire logic       host_protocol_pin, // SPI selected
  input wire logic       spi_ss_n,          // Frame select
  input wire logic       spi_miso_oe,       // Drive enable
  input wire logic       loc_rd,            // Local read strobe
  input wire logic       loc_wr,            // Local write strobe
  input wire logic [3:0] ds_req,            // Port starts
  input wire logic [3:0] ds_done,           // Port completions
  input wire logic [3:0] port_busy          // Port busy
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // Any command strobe
  wire logic stb = loc_rd || loc_wr || (ds_req != 4'h0);
  a_off_deselected: assert property (!host_protocol_pin [*8] |-> !spi_miso_oe && !stb)
    else $error("drive or strobe with SPI off");
  a_on_in_frame: assert property ((!spi_ss_n && host_protocol_pin) [*8] |-> spi_miso_oe)
    else $error("miso not driven in frame");
  a_idle_released: assert property (spi_ss_n [*8] |-> !spi_miso_oe)
    else $error("miso driven between frames");
  a_strobe_after_rise: assert property (stb |-> spi_ss_n && $past(spi_ss_n, 3))
    else $error("strobe before select rise");
  a_strobe_once: assert property (stb |=> !stb)
    else $error("strobe longer than one cycle");
  a_port_refused: assert property ($onehot0(ds_req) && (ds_req & port_busy) == 4'h0)
    else $error("request to busy or several ports");
  a_busy_follows: assert property (ds_req != 4'h0 |-> ##2 (port_busy & $past(ds_req, 2)) != 4'h0)
    else $error("port not busy after request");
  a_clear_by_done: assert property ((($past(port_busy) & ~port_busy) & ~$past(ds_done, 2)) == 4'h0)
    else $error("busy cleared without done");
endmodule
bind sps_spi_seq sps_chk u_chk (.clk(clk), .nrst(nrst), .host_protocol_pin(host_protocol_pin),
  .spi_ss_n(spi_ss_n), .spi_miso_oe(spi_miso_oe), .loc_rd(loc_rd), .loc_wr(loc_wr), .ds_req(ds_req),
  .ds_done(ds_done), .port_busy(port_busy));
`default_nettype wire

// *** verification/test_sps_spi_seq.sv ***
// Self-checking bench for the SPI host port sequencer
`timescale 1ns/1ns
`default_nettype none
`include "sps_map.vh"
module test_sps_spi_seq;
  logic        clk = 1'b0, nrst = 1'b0, pin = 1'b1;
  logic        ss_n, sck, mosi, miso, oe, lrd, lwr, rnw, dev;
  logic [7:0]  la, lwd, da, dwd;
  logic [3:0]  req, busy, done = 4'h0;
  logic [31:0] rdat = 32'h0;
  logic [10:0] cnt [4] = '{default: 11'h000};
  logic [15:0] wr_seen = 16'h0;
  logic [21:0] ds_seen = 22'h0;
  logic [28:0] rx;
  int          failures = 0, checks = 0, nstb = 0;
  initial begin
    forever #20 clk = ~clk;
  end
  sps_spi_seq uut (.clk(clk), .nrst(nrst), .host_protocol_pin(pin), .spi_sck(sck), .spi_ss_n(ss_n),
    .spi_mosi(mosi), .spi_miso(miso), .spi_miso_oe(oe), .loc_rd(lrd), .loc_wr(lwr), .loc_addr(la),
    .loc_wdata(lwd), .loc_rdata(la ^ 8'h5A), .ds_req(req), .ds_rnw(rnw), .ds_dev(dev), .ds_addr(da),
    .ds_wdata(dwd), .ds_done(done), .ds_rdata(rdat), .ds_nack(4'h8), .port_busy(busy));
  sps_host u_host (.clk(clk), .miso(oe ? miso : ~miso), .ss_n(ss_n), .sck(sck), .mosi(mosi));
  // Ports answer 1000 cycles after a start, port 3 with a nack
  always @(negedge clk) begin
    for (int p = 0; p < 4; p++) begin
      done[p] <= !req[p] && cnt[p] == 11'h001;
      if (req[p]) begin
        cnt[p] <= 11'h3E8;
        rdat[8*p+:8] <= da ^ 8'hC3;
      end else if (cnt[p] != 11'h000) cnt[p] <= cnt[p] - 11'h001;
    end
  end
  // Record strobes and what they carried
  always @(posedge clk) begin
    if (lwr) wr_seen <= {la, lwd};
    if (req != 4'h0) ds_seen <= {req, rnw, dev, da, dwd};
    if (lrd || lwr || req != 4'h0) nstb <= nstb + 1;
  end
  task automatic chk(input string what, input logic [28:0] exp, input logic [28:0] got);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic fr(input logic [28:0] tx, input int gap);
    u_host.xfer(tx, gap, rx);
  endtask
  task automatic idle(input int p);
    repeat (10) @(negedge clk);
    for (int k = 0; k < 3000 && busy[p] !== 1'b0; k++) @(negedge clk);
    chk("port idle", 29'h0, {28'h0, busy[p]});
  endtask
  // Local write, local read collected by all-ones frames
  task automatic t_local;
    int n;
    fr(29'h0805003C, `SPS_LOC_GAP_CYC);
    chk("write strobe", 29'h053C, {13'h0, wr_seen});
    fr(29'h18120000, `SPS_LOC_GAP_CYC);
    chk("write echo", 29'h0805003C, rx);
    n = nstb;
    fr(29'h1FFFFFFF, `SPS_LOC_GAP_CYC);
    chk("local read", 29'h18120048, rx);
    fr(29'h1FFFFFFF, `SPS_LOC_GAP_CYC);
    chk("dummy echo", 29'h1FFFFFFF, rx);
    chk("dummy strobes", 29'(n), 29'(nstb));
  endtask
  // Frames ignored while the SPI port is not selected
  task automatic t_pin;
    pin = 1'b0;
    repeat (10) @(negedge clk);
    fr(29'h08070011, 40);
    chk("off write", 29'h053C, {13'h0, wr_seen});
    pin = 1'b1;
    repeat (10) @(negedge clk);
    fr(29'h1FFFFFFF, 40);
    chk("kept result", 29'h1FFFFFFF, rx);
  endtask
  // Early result, reject, other port while busy, then real data
  task automatic t_ds;
    fr(29'h12A00000, 10);
    chk("port request", 29'h0AA0, {15'h0, ds_seen[21:8]});
    fr(29'h12A20000, 10);
    chk("early result", {1'b1, 12'h2A0, `SPS_BUSY_WORD}, rx);
    fr(29'h04A00077, 10);
    chk("reject", {1'b1, 12'h2A2, `SPS_REJ_WORD}, rx);
    chk("other port", 29'h10A077, {7'h0, ds_seen});
    fr(29'h1FFFFFFF, 10);
    chk("port write echo", 29'h04A00077, rx);
    idle(1);
    fr(29'h12A00000, 10);
    idle(1);
    fr(29'h17A20000, 10);
    chk("port data", 29'h12A00063, rx);
    idle(3);
    fr(29'h1FFFFFFF, 10);
    chk("nack data", 29'h17A22061, rx);
  endtask
  task automatic complete_run;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (10) @(negedge clk);
    nrst = 1'b1;
    repeat (10) @(negedge clk);
    t_local();
    t_pin();
    t_ds();
    complete_run();
  end
  // Watchdog, about three and a half times the expected run
  initial begin
    #800000;
    failures++;
    complete_run();
  end
endmodule
`default_nettype wire
